// ---- rtl/drcs_top.sv ----
// run command and frequency reference source selection
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps
`include "drcs_cfg.svh"
module drcs_top #(
  parameter int TICK_CYC = `DRCS_TICK_CYC
) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // input terminals
  input wire logic [5:0] di_i,
  // keypad
  input wire logic keypad_run_i,
  input wire logic keypad_stop_i,
  input wire logic direction_toggle_key_i,
  // rs485 port commands
  input wire logic rs485_run_i,
  input wire logic rs485_stop_i,
  input wire logic rs485_rev_i,
  // program logic and timer schedule
  input wire logic plc_run_i,
  input wire logic plc_rev_i,
  input wire logic rtc_run_i,
  // frequency sources
  input wire logic [15:0] ai1_frq_i,
  input wire logic [15:0] updown_frq_i,
  input wire logic [15:0] comm_frq_i,
  input wire logic [15:0] rtc_frq_i,
  input wire logic [15:0] ai2_frq_i,
  // drive outputs
  output logic run_o,
  output logic rev_o,
  output logic [16:0] frq_ref_o,
  output logic vf_mode_o,
  output logic sensorless_vector_mode_o,
  output logic pm_sensorless_vector_mode_o,
  output logic [3:0] stall_cfg_o,
  output logic both_directions_alarm_o,
  output logic mode_conflict_error_o
);
  drcs_di_if di ();
  logic [2:0] mode_reg;
  logic dir_reg;
  logic [1:0] lock_reg;
  logic [2:0] rs_main_reg, rs_alt_reg, fs_main_reg, fs_alt_reg;
  logic comb_reg;
  logic [47:0] fn_reg;
  logic [15:0] kp_frq_reg, stage0_reg;
  logic [3:0] stall_reg;
  logic kp_run_reg, com_run_reg;
  logic [9:0] hold_reg [3];
  logic [9:0] alm_reg;
  drcs_pkg::drcs_term_state_t ts_reg, ts_next;
  drcs_pkg::drcs_term_mode_t tmode;
  logic [2:0] hold_ok;
  logic [2:0] rsel;
  logic run_alt, frq_alt, fwd_in, rev_in, dir3, conflict;
  logic req_run, req_rev, locked, pm_mode;
  logic [15:0] frq_main, frq_alt_v;
  logic wr, rd_ok;
  logic [31:0] rd_next;
  logic [3:0] init_code;

  drcs_di_cond #(.TICK_CYC(TICK_CYC)) u_cond (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .di_i(di_i),
    .di(di.src)
  );

  // which terminals carry a given function code
  function automatic logic [5:0] fn_hit(input logic [47:0] f, input logic [7:0] c);
    for (int i = 0; i < 6; i++) begin
      fn_hit[i] = (f[8*i +: 8] == c);
    end
  endfunction

  // merge of a bus write under byte enables
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
    end
  endfunction

  // reserved codes give zero frequency
  function automatic logic [15:0] frq_of(input logic [2:0] c, input logic [15:0] kp,
                                         input logic [15:0] a1, input logic [15:0] ud,
                                         input logic [15:0] cm, input logic [15:0] rt,
                                         input logic [15:0] a2);
    unique case (c)
      drcs_pkg::DRCS_FS_KEYPAD: frq_of = kp;
      drcs_pkg::DRCS_FS_AI1: frq_of = a1;
      drcs_pkg::DRCS_FS_UPDN: frq_of = ud;
      drcs_pkg::DRCS_FS_COMM: frq_of = cm;
      drcs_pkg::DRCS_FS_RTC: frq_of = rt;
      drcs_pkg::DRCS_FS_AI2: frq_of = a2;
      default: frq_of = 16'h0000;
    endcase
  endfunction

  // bus: ack one cycle after the strobe, dropped the next
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign init_code = (wr && wb_adr_i == `DRCS_A_INIT && wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;
  assign pm_mode = (mode_reg == drcs_pkg::DRCS_CM_PM);

  // terminal decode
  assign conflict = |fn_hit(fn_reg, `DRCS_FN_LATCH) & |fn_hit(fn_reg, `DRCS_FN_3W);
  always_comb begin
    if (conflict) begin
      tmode = drcs_pkg::DRCS_TM_NONE;
    end else if (|fn_hit(fn_reg, `DRCS_FN_LATCH)) begin
      tmode = drcs_pkg::DRCS_TM_LATCH;
    end else if (|(fn_hit(fn_reg, `DRCS_FN_3W) & 6'h3C)) begin
      tmode = drcs_pkg::DRCS_TM_THREE;
    end else begin
      tmode = drcs_pkg::DRCS_TM_TWO;
    end
  end
  assign fwd_in = |(fn_hit(fn_reg, `DRCS_FN_FWD) & di.lvl);
  assign rev_in = |(fn_hit(fn_reg, `DRCS_FN_REV) & di.lvl);
  assign dir3 = |(fn_hit(fn_reg, `DRCS_FN_3W) & di.lvl & 6'h3C);
  assign run_alt = |(fn_hit(fn_reg, `DRCS_FN_RSW) & di.lvl);
  assign frq_alt = |(fn_hit(fn_reg, `DRCS_FN_FSW) & di.lvl);

  // hold timers on inputs one, two and five; one extra tick covers phase
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_hold
      localparam int PIN = (g == 2) ? 4 : g;
      always_ff @(posedge clk_i) begin
        if (rst_i || !di.lvl[PIN]) begin
          hold_reg[g] <= 10'h000;
        end else if (di.tick && hold_reg[g] != `DRCS_HOLD_TICKS) begin
          hold_reg[g] <= hold_reg[g] + 10'h001;
        end
      end
      assign hold_ok[g] = (hold_reg[g] == `DRCS_HOLD_TICKS);
    end
  endgenerate

  // both-closed alarm timer, two-wire only
  always_ff @(posedge clk_i) begin
    if (rst_i || !(fwd_in && rev_in && tmode == drcs_pkg::DRCS_TM_TWO)) begin
      alm_reg <= 10'h000;
      both_directions_alarm_o <= 1'b0;
    end else begin
      if (di.tick && alm_reg != `DRCS_ALARM_TICKS) begin
        alm_reg <= alm_reg + 10'h001;
      end
      both_directions_alarm_o <= (alm_reg == `DRCS_ALARM_TICKS);
    end
  end

  // terminal run state
  always_comb begin
    ts_next = ts_reg;
    unique case (tmode)
      drcs_pkg::DRCS_TM_TWO: begin
        if (fwd_in && !rev_in) begin
          ts_next = drcs_pkg::DRCS_TS_FWD;
        end else if (rev_in && !fwd_in) begin
          ts_next = drcs_pkg::DRCS_TS_REV;
        end else begin
          ts_next = drcs_pkg::DRCS_TS_STOP;
        end
      end
      drcs_pkg::DRCS_TM_THREE: begin
        if (!di.lvl[1]) begin
          ts_next = drcs_pkg::DRCS_TS_STOP;
        end else if (ts_reg != drcs_pkg::DRCS_TS_STOP || hold_ok[0]) begin
          // short run pulses never start the drive
          ts_next = dir3 ? drcs_pkg::DRCS_TS_REV : drcs_pkg::DRCS_TS_FWD;
        end
      end
      drcs_pkg::DRCS_TM_LATCH: begin
        if (!di.lvl[4]) begin
          ts_next = drcs_pkg::DRCS_TS_STOP;
        end else if (hold_ok[2] && hold_ok[0]) begin
          ts_next = drcs_pkg::DRCS_TS_FWD;
        end else if (hold_ok[2] && hold_ok[1]) begin
          ts_next = drcs_pkg::DRCS_TS_REV;
        end
      end
      drcs_pkg::DRCS_TM_NONE: ts_next = drcs_pkg::DRCS_TS_STOP;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ts_reg <= drcs_pkg::DRCS_TS_STOP;
    end else begin
      ts_reg <= ts_next;
    end
  end

  // keypad and rs485 run latches; stop wins for safety
  always_ff @(posedge clk_i) begin
    if (rst_i || keypad_stop_i) begin
      kp_run_reg <= 1'b0;
    end else if (keypad_run_i) begin
      kp_run_reg <= 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || rs485_stop_i) begin
      com_run_reg <= 1'b0;
    end else if (rs485_run_i) begin
      com_run_reg <= 1'b1;
    end
  end

  // active run source and request
  assign rsel = run_alt ? rs_alt_reg : rs_main_reg;
  always_comb begin
    unique case (rsel)
      drcs_pkg::DRCS_RS_KEYPAD: begin
        req_run = kp_run_reg;
        req_rev = dir_reg;
      end
      drcs_pkg::DRCS_RS_TERM: begin
        req_run = (ts_reg != drcs_pkg::DRCS_TS_STOP);
        req_rev = (ts_reg == drcs_pkg::DRCS_TS_REV);
      end
      drcs_pkg::DRCS_RS_COMM: begin
        req_run = com_run_reg;
        req_rev = rs485_rev_i;
      end
      drcs_pkg::DRCS_RS_PLC: begin
        req_run = plc_run_i;
        req_rev = plc_rev_i;
      end
      drcs_pkg::DRCS_RS_RTC: begin
        req_run = rtc_run_i;
        req_rev = dir_reg;
      end
      default: begin
        req_run = 1'b0;
        req_rev = 1'b0;
      end
    endcase
  end
  // lock 1 bars reverse, lock 2 bars forward
  assign locked = (lock_reg == 2'h1 && req_rev) || (lock_reg == 2'h2 && !req_rev);

  // drive outputs from flops
  assign frq_main = frq_of(fs_main_reg, kp_frq_reg, ai1_frq_i, updown_frq_i, comm_frq_i,
                           rtc_frq_i, ai2_frq_i);
  assign frq_alt_v = frq_of(fs_alt_reg, stage0_reg, ai1_frq_i, updown_frq_i, comm_frq_i,
                            rtc_frq_i, ai2_frq_i);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_o <= 1'b0;
      rev_o <= 1'b0;
      frq_ref_o <= 17'h00000;
    end else begin
      run_o <= req_run && !locked;
      rev_o <= req_run && !locked && req_rev;
      if (comb_reg) begin
        frq_ref_o <= {1'b0, frq_main} + {1'b0, frq_alt_v};
      end else if (frq_alt) begin
        frq_ref_o <= {1'b0, frq_alt_v};
      end else begin
        frq_ref_o <= {1'b0, frq_main};
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vf_mode_o <= 1'b0;
      sensorless_vector_mode_o <= 1'b0;
      pm_sensorless_vector_mode_o <= 1'b0;
      stall_cfg_o <= 4'h0;
      mode_conflict_error_o <= 1'b0;
    end else begin
      vf_mode_o <= (mode_reg == drcs_pkg::DRCS_CM_VF);
      sensorless_vector_mode_o <= (mode_reg == drcs_pkg::DRCS_CM_SLV);
      pm_sensorless_vector_mode_o <= pm_mode;
      stall_cfg_o <= stall_reg | (pm_mode ? 4'h2 : 4'h0);
      mode_conflict_error_o <= conflict;
    end
  end

  // control mode survives initialization
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= 3'h0;
    end else if (wr && wb_adr_i == `DRCS_A_MODE && wb_sel_i[0]) begin
      mode_reg <= wb_dat_i[2:0];
    end
  end

  // direction: toggle key acts on top of a same-cycle write
  always_ff @(posedge clk_i) begin
    if (rst_i || init_code != 4'h0) begin
      dir_reg <= 1'b0;
      lock_reg <= 2'h0;
    end else begin
      if (wr && wb_adr_i == `DRCS_A_DIR && wb_sel_i[0]) begin
        dir_reg <= wb_dat_i[0] ^ (direction_toggle_key_i && rsel == 3'h0);
        lock_reg <= wb_dat_i[`DRCS_LOCK_LSB +: 2];
      end else if (direction_toggle_key_i && rsel == 3'h0) begin
        dir_reg <= !dir_reg;
      end
    end
  end

  // settings; codes 1..15 restore defaults, 3/5/7 pick three-wire
  always_ff @(posedge clk_i) begin
    if (rst_i || init_code != 4'h0) begin
      rs_main_reg <= 3'h0;
      rs_alt_reg <= 3'h0;
      fs_main_reg <= 3'h0;
      fs_alt_reg <= 3'h0;
      comb_reg <= 1'b0;
      fn_reg <= (init_code >= 4'h3 && init_code <= 4'h7 && init_code[0]) ?
                `DRCS_INIT_3W_FN : `DRCS_RST_FN;
      kp_frq_reg <= 16'h0000;
      stage0_reg <= 16'h0000;
      stall_reg <= 4'h0;
    end else if (wr) begin
      unique case (wb_adr_i)
        `DRCS_A_RUNSRC: begin
          if (wb_sel_i[0]) begin
            rs_main_reg <= wb_dat_i[2:0];
            rs_alt_reg <= wb_dat_i[`DRCS_ALT_LSB +: 3];
          end
        end
        `DRCS_A_FRQSRC: begin
          if (wb_sel_i[0]) begin
            fs_main_reg <= wb_dat_i[2:0];
            fs_alt_reg <= wb_dat_i[`DRCS_ALT_LSB +: 3];
          end
          if (wb_sel_i[1]) begin
            comb_reg <= wb_dat_i[`DRCS_COMB_BIT];
          end
        end
        `DRCS_A_FN_LO: fn_reg[31:0] <= merge(fn_reg[31:0], wb_dat_i, wb_sel_i);
        `DRCS_A_FN_HI: fn_reg[47:32] <= 16'(merge({16'h0000, fn_reg[47:32]}, wb_dat_i,
                                                  wb_sel_i));
        `DRCS_A_KPFRQ: kp_frq_reg <= 16'(merge({16'h0000, kp_frq_reg}, wb_dat_i, wb_sel_i));
        `DRCS_A_STAGE0: stage0_reg <= 16'(merge({16'h0000, stage0_reg}, wb_dat_i, wb_sel_i));
        `DRCS_A_STALL: begin
          if (wb_sel_i[0]) begin
            stall_reg <= wb_dat_i[3:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // read mux; unmapped offsets read zero and still ack
  always_comb begin
    rd_ok = 1'b1;
    unique case (wb_adr_i)
      `DRCS_A_MODE: rd_next = {29'h0, mode_reg};
      `DRCS_A_DIR: rd_next = {26'h0, lock_reg, 3'h0, dir_reg};
      `DRCS_A_RUNSRC: rd_next = {25'h0, rs_alt_reg, 1'b0, rs_main_reg};
      `DRCS_A_FRQSRC: rd_next = {23'h0, comb_reg, 1'b0, fs_alt_reg, 1'b0, fs_main_reg};
      `DRCS_A_FN_LO: rd_next = fn_reg[31:0];
      `DRCS_A_FN_HI: rd_next = {16'h0, fn_reg[47:32]};
      `DRCS_A_KPFRQ: rd_next = {16'h0, kp_frq_reg};
      `DRCS_A_STAGE0: rd_next = {16'h0, stage0_reg};
      `DRCS_A_STALL: rd_next = {28'h0, stall_reg | (pm_mode ? 4'h2 : 4'h0)};
      `DRCS_A_STATUS: rd_next = {21'h0, rsel, frq_alt, run_alt, tmode, conflict,
                                 both_directions_alarm_o, rev_o, run_o};
      default: begin
        rd_next = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= (rd_ok && !wb_we_i) ? rd_next : 32'h0000_0000;
    end
  end
endmodule

// ---- include/drcs_cfg.svh ----
// constants for the run command and reference selection block
`ifndef DRCS_CFG_SVH
`define DRCS_CFG_SVH
`define DRCS_CLK_HZ 50000000
`define DRCS_TICK_US 1000
`define DRCS_TICK_CYC ((`DRCS_CLK_HZ / 1000000) * `DRCS_TICK_US)
`define DRCS_HOLD_MS 50
`define DRCS_ALARM_MS 500
`define DRCS_HOLD_TICKS 10'(`DRCS_HOLD_MS + 1)
`define DRCS_ALARM_TICKS 10'(`DRCS_ALARM_MS + 1)
`define DRCS_A_MODE 8'h00
`define DRCS_A_DIR 8'h04
`define DRCS_A_RUNSRC 8'h08
`define DRCS_A_FRQSRC 8'h0C
`define DRCS_A_FN_LO 8'h10
`define DRCS_A_FN_HI 8'h14
`define DRCS_A_INIT 8'h18
`define DRCS_A_KPFRQ 8'h1C
`define DRCS_A_STAGE0 8'h20
`define DRCS_A_STALL 8'h24
`define DRCS_A_STATUS 8'h28
`define DRCS_ALT_LSB 4
`define DRCS_LOCK_LSB 4
`define DRCS_COMB_BIT 8
`define DRCS_STALL_DECEL_BIT 1
`define DRCS_FN_FWD 8'h00
`define DRCS_FN_REV 8'h01
`define DRCS_FN_RSW 8'h0C
`define DRCS_FN_FSW 8'h0D
`define DRCS_FN_3W 8'h1A
`define DRCS_FN_LATCH 8'h35
`define DRCS_FN_NONE 8'h0F
`define DRCS_RST_FN 48'h0F0F_0F0F_0100
`define DRCS_INIT_3W_FN 48'h0F1A_0F0F_0100
`endif

// ---- include/drcs_pkg.sv ----
// types for the run command and reference selection block
package drcs_pkg;
  typedef enum logic [2:0] {
    DRCS_CM_VF = 3'h0,
    DRCS_CM_SLV = 3'h2,
    DRCS_CM_PM = 3'h5
  } drcs_ctrl_mode_t;
  typedef enum logic [2:0] {
    DRCS_RS_KEYPAD = 3'h0,
    DRCS_RS_TERM = 3'h1,
    DRCS_RS_COMM = 3'h2,
    DRCS_RS_PLC = 3'h3,
    DRCS_RS_RTC = 3'h4
  } drcs_run_src_t;
  typedef enum logic [2:0] {
    DRCS_FS_KEYPAD = 3'h0,
    DRCS_FS_AI1 = 3'h1,
    DRCS_FS_UPDN = 3'h2,
    DRCS_FS_COMM = 3'h3,
    DRCS_FS_RTC = 3'h6,
    DRCS_FS_AI2 = 3'h7
  } drcs_frq_src_t;
  typedef enum logic [1:0] {
    DRCS_TM_TWO = 2'h0,
    DRCS_TM_THREE = 2'h1,
    DRCS_TM_LATCH = 2'h3,
    DRCS_TM_NONE = 2'h2
  } drcs_term_mode_t;
  typedef enum logic [1:0] {
    DRCS_TS_STOP = 2'h0,
    DRCS_TS_FWD = 2'h1,
    DRCS_TS_REV = 2'h3
  } drcs_term_state_t;
endpackage

// ---- include/drcs_di_if.sv ----
// conditioned terminal levels and the millisecond tick
`timescale 1ns/10ps
interface drcs_di_if;
  logic [5:0] lvl;
  logic tick;
  modport src (output lvl, output tick);
  modport snk (input lvl, input tick);
endinterface

// ---- rtl/drcs_di_cond.sv ----
// input terminal synchroniser and millisecond tick divider
`timescale 1ns/10ps
`include "drcs_cfg.svh"
module drcs_di_cond #(
  parameter int TICK_CYC = `DRCS_TICK_CYC
) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // terminals
  input wire logic [5:0] di_i,
  // conditioned side
  drcs_di_if.src di
);
  logic [15:0] div_reg;
  genvar g;
  // three stages, level moves only when stages two and three agree
  generate
    for (g = 0; g < 6; g++) begin : g_sync
      logic [2:0] sh_reg;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sh_reg <= 3'h0;
          di.lvl[g] <= 1'b0;
        end else begin
          sh_reg <= {sh_reg[1:0], di_i[g]};
          if (sh_reg[1] == sh_reg[2]) begin
            di.lvl[g] <= sh_reg[2];
          end
        end
      end
    end
  endgenerate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= 16'h0000;
      di.tick <= 1'b0;
    end else begin
      di.tick <= (div_reg == 16'(TICK_CYC - 1));
      div_reg <= (div_reg == 16'(TICK_CYC - 1)) ? 16'h0000 : div_reg + 16'h0001;
    end
  end
endmodule

// ---- tb/drcs_switch_model.sv ----
// operator switch model on the input terminals
`timescale 1ns/10ps
module drcs_switch_model #(
  parameter int HOLD_CYC = 600
) (
  // system
  input wire logic clk_i,
  // wanted switch positions
  input wire logic [5:0] want_i,
  input wire logic short_i,
  // terminal levels
  output logic [5:0] di_o
);
  int cnt [6];
  initial di_o = 6'h00;
  // a closed switch stays closed for the minimum hold unless a jab is asked for
  always @(posedge clk_i) begin
    for (int i = 0; i < 6; i++) begin
      if (want_i[i] && !di_o[i]) begin
        di_o[i] <= 1'b1;
        cnt[i] <= 0;
      end else if (!want_i[i] && di_o[i] && (short_i || cnt[i] >= HOLD_CYC)) begin
        di_o[i] <= 1'b0;
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule

// ---- tb/drcs_checker.sv ----
// assertion checker for the run command selection block
`timescale 1ns/10ps
`include "drcs_cfg.svh"
module drcs_checker (
  // system and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // terminals and drive outputs
  input wire logic [5:0] di_i,
  input wire logic run_o,
  input wire logic rev_o,
  input wire logic vf_mode_o,
  input wire logic sensorless_vector_mode_o,
  input wire logic pm_sensorless_vector_mode_o,
  input wire logic [3:0] stall_cfg_o,
  input wire logic both_directions_alarm_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_init;
    wb_ack_o && $past(wb_we_i && wb_adr_i == `DRCS_A_INIT);
  endsequence
  chk_ack_latency: assert property (s_req |=> wb_ack_o)
    else $error("ack late");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_wdat_zero: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0000_0000)
    else $error("write ack carries data");
  chk_mode_onehot: assert property (
    $onehot0({vf_mode_o, sensorless_vector_mode_o, pm_sensorless_vector_mode_o}))
    else $error("two modes at once");
  chk_pm_stall: assert property (pm_sensorless_vector_mode_o [*2] |-> stall_cfg_o[1])
    else $error("decel stall not disabled");
  chk_rev_run: assert property (rev_o |-> run_o)
    else $error("reverse without run");
  chk_alarm_cause: assert property (
    $rose(both_directions_alarm_o) |-> !run_o && $past(di_i[0] && di_i[1], 8))
    else $error("alarm without both inputs");
  chk_init_keep: assert property (s_init |=>
    $stable({vf_mode_o, sensorless_vector_mode_o, pm_sensorless_vector_mode_o}) [*3])
    else $error("mode moved on init");
endmodule
bind drcs_top drcs_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .di_i, .run_o, .rev_o, .vf_mode_o, .sensorless_vector_mode_o,
  .pm_sensorless_vector_mode_o, .stall_cfg_o, .both_directions_alarm_o);

// ---- tb/test_drcs_top.sv ----
// self-checking bench for the run command selection block
`timescale 1ns/10ps
`include "drcs_cfg.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, (g), (e)); end end
module test_drcs_top;
  localparam int TK = 10;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, rd;
  logic ack, run, rev, alarm, conflict;
  logic [4:0] pl = 5'h00;
  logic [3:0] lv = 4'h0;
  logic [5:0] want = 6'h00;
  logic jab = 1'b1;
  logic [5:0] di;
  logic [2:0] md;
  logic [3:0] stall;
  logic [16:0] frq;
  int fail_count = 0;
  int tests_run = 0;
  int ncyc = 0;
  drcs_top #(.TICK_CYC(TK)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .di_i(di), .keypad_run_i(pl[0]),
    .keypad_stop_i(pl[1]), .direction_toggle_key_i(pl[2]), .rs485_run_i(pl[3]),
    .rs485_stop_i(pl[4]), .rs485_rev_i(lv[3]), .plc_run_i(lv[0]), .plc_rev_i(lv[1]),
    .rtc_run_i(lv[2]), .ai1_frq_i(16'h1111), .updown_frq_i(16'h2222),
    .comm_frq_i(16'h3333), .rtc_frq_i(16'h6666), .ai2_frq_i(16'h7777), .run_o(run),
    .rev_o(rev), .frq_ref_o(frq), .vf_mode_o(md[0]), .sensorless_vector_mode_o(md[1]),
    .pm_sensorless_vector_mode_o(md[2]), .stall_cfg_o(stall),
    .both_directions_alarm_o(alarm), .mode_conflict_error_o(conflict));
  drcs_switch_model #(.HOLD_CYC(60 * TK)) u_sw (.clk_i(clk_i), .want_i(want),
    .short_i(jab), .di_o(di));
  initial forever #10 clk_i = ~clk_i;
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // hang guard, well above the alarm wait
  always @(posedge clk_i) begin
    ncyc++;
    if (ncyc == 40000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // request held until ack is sampled high at a rising edge; the hang guard ends a stall
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    wt(3);
  endtask
  task automatic pulse(input logic [4:0] v);
    @(posedge clk_i);
    pl <= v;
    @(posedge clk_i);
    pl <= 5'h00;
    wt(3);
  endtask
  task automatic sw(input logic [5:0] w, input int n);
    @(posedge clk_i);
    want <= w;
    wt(n);
  endtask
  task automatic lvl(input logic [3:0] v);
    @(posedge clk_i);
    lv <= v;
    wt(4);
  endtask
  task automatic t_regs();
    bus(0, `DRCS_A_FN_LO, 0);
    `CHK(rd, 32'h0F0F_0100)
    bus(0, 8'h3C, 0);
    `CHK(rd, 32'h0)
  endtask
  task automatic t_modes();
    for (int c = 0; c < 8; c++) begin
      bus(1, `DRCS_A_MODE, c);
      `CHK(md, {c == 5, c == 2, c == 0})
      bus(0, `DRCS_A_STALL, 0);
      `CHK(rd[1], c == 5)
      `CHK(stall[1], c == 5)
    end
    bus(1, `DRCS_A_MODE, 5);
    bus(1, `DRCS_A_INIT, 1);
    `CHK(md, 3'b100)
    bus(1, `DRCS_A_MODE, 0);
  endtask
  task automatic t_two();
    bus(1, `DRCS_A_RUNSRC, 1);
    sw(6'h01, 12);
    `CHK({run, rev}, 2'b10)
    sw(6'h02, 12);
    `CHK({run, rev}, 2'b11)
    sw(6'h03, 4800);
    `CHK({run, alarm}, 2'b00)
    wt(500);
    `CHK(alarm, 1'b1)
    sw(6'h00, 12);
    `CHK({run, alarm}, 2'b00)
    bus(1, `DRCS_A_DIR, 32'h10);
    sw(6'h02, 12);
    `CHK(run, 1'b0)
    sw(6'h01, 12);
    `CHK({run, rev}, 2'b10)
    sw(6'h00, 12);
    bus(1, `DRCS_A_DIR, 0);
  endtask
  task automatic t_src();
    bus(1, `DRCS_A_RUNSRC, 0);
    pulse(5'h01);
    `CHK({run, rev}, 2'b10)
    pulse(5'h04);
    `CHK({run, rev}, 2'b11)
    pulse(5'h02);
    `CHK(run, 1'b0)
    bus(1, `DRCS_A_RUNSRC, 2);
    pulse(5'h01);
    `CHK(run, 1'b0)
    pulse(5'h08);
    `CHK(run, 1'b1)
    pulse(5'h10);
    `CHK(run, 1'b0)
    bus(1, `DRCS_A_RUNSRC, 3);
    lvl(4'h3);
    `CHK({run, rev}, 2'b11)
    bus(1, `DRCS_A_RUNSRC, 4);
    lvl(4'h4);
    `CHK({run, rev}, 2'b11)
    bus(1, `DRCS_A_FN_LO, 32'h0F0C_0100);
    bus(1, `DRCS_A_RUNSRC, 32'h41);
    sw(6'h04, 12);
    bus(0, `DRCS_A_STATUS, 0);
    `CHK(rd[10:8], 3'h4)
    sw(6'h00, 12);
    `CHK(run, 1'b0)
    lvl(4'h0);
  endtask
  task automatic t_three();
    bus(1, `DRCS_A_INIT, 3);
    bus(1, `DRCS_A_RUNSRC, 1);
    bus(0, `DRCS_A_FN_HI, 0);
    `CHK(rd, 32'h0000_0F1A)
    sw(6'h03, 200);
    sw(6'h02, 12);
    `CHK(run, 1'b0)
    jab <= 1'b0;
    sw(6'h03, 700);
    sw(6'h02, 12);
    `CHK({run, rev}, 2'b10)
    bus(0, `DRCS_A_STATUS, 0);
    `CHK(rd[5:4], 2'h1)
    jab <= 1'b1;
    sw(6'h00, 12);
    `CHK(run, 1'b0)
  endtask
  task automatic t_conflict();
    bus(1, `DRCS_A_FN_HI, 32'h351A);
    `CHK(conflict, 1'b1)
    bus(1, `DRCS_A_FN_HI, 32'h0F35);
    bus(0, `DRCS_A_STATUS, 0);
    `CHK({conflict, rd[5:4]}, 3'h3)
    jab <= 1'b0;
    sw(6'h11, 700);
    sw(6'h10, 12);
    `CHK({run, rev}, 2'b10)
    jab <= 1'b1;
    sw(6'h00, 12);
    `CHK(run, 1'b0)
    bus(1, `DRCS_A_INIT, 2);
    bus(0, `DRCS_A_STATUS, 0);
    `CHK(rd[5:4], 2'h0)
  endtask
  task automatic t_freq();
    logic [15:0] exp_f [8];
    exp_f = '{16'h0ABC, 16'h1111, 16'h2222, 16'h3333, 16'h0, 16'h0, 16'h6666, 16'h7777};
    bus(1, `DRCS_A_KPFRQ, 32'h0ABC);
    bus(1, `DRCS_A_STAGE0, 32'h0DEF);
    for (int c = 0; c < 8; c++) begin
      bus(1, `DRCS_A_FRQSRC, c);
      `CHK(frq, {1'b0, exp_f[c]})
    end
    bus(1, `DRCS_A_FRQSRC, 32'h101);
    `CHK(frq, 17'h01F00)
    bus(1, `DRCS_A_FRQSRC, 32'h01);
    bus(1, `DRCS_A_FN_LO, 32'h0F0D_0100);
    sw(6'h04, 12);
    `CHK(frq, 17'h00DEF)
    sw(6'h00, 12);
    `CHK(frq, 17'h01111)
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_modes();
    t_two();
    t_src();
    t_three();
    t_conflict();
    t_freq();
    final_report();
  end
endmodule
